// File: rtl/slave_addr_decode.sv
/*
  slave address decoder with chained-board logic and power-up defaults.
  assumes address, modifier and strobes are synchronous to i_clock and
  the buffer clear pulse empties one word per cycle.
*/
`timescale 1ns/1ps
module slave_addr_decode
    import addr_decode_pkg::*;
#(
    parameter int CONFIG_COUNT = CONFIG_CYCLES,
    parameter int CLEAR_COUNT  = BUF_CLEAR_WORDS
) (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_switch_d3,
    input  wire logic [3:0]  i_switch_d2,
    input  wire logic [3:0]  i_switch_d1,
    input  wire logic [3:0]  i_switch_d0,
    input  wire logic [31:0] i_addr,
    input  wire logic [5:0]  i_am,
    input  wire logic        i_write,
    input  wire logic        i_strobe,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_iack_in_n,
    input  wire logic        i_board_done,
    input  wire logic        i_buf_full,
    input  wire logic        i_tdc_error,
    input  wire logic        i_data_ready,
    output logic             o_select,
    output logic [1:0]       o_access,
    output logic [15:0]      o_offset,
    output logic             o_iack_out_n,
    output logic [7:0]       o_chain_byte,
    output logic [1:0]       o_chain_pos,
    output logic [4:0]       o_geo,
    output logic             o_buf_clear,
    output logic             o_acq_ready,
    output logic             o_trig_match,
    output logic [15:0]      o_win_width,
    output logic [15:0]      o_win_offset,
    output logic [15:0]      o_extra_search,
    output logic [15:0]      o_reject_margin,
    output logic             o_edge_leading,
    output logic [9:0]       o_fifo_size,
    output logic [7:0]       o_max_hits,
    output logic             o_all_chan_en,
    output logic [11:0]      o_chan_offset,
    output logic             o_full_lamp,
    output logic             o_error_lamp,
    output logic             o_data_ready_lamp
);
    localparam int CNT_W      = $clog2(CONFIG_COUNT + CLEAR_COUNT + 1);
    localparam int LAMP_COUNT = 3;
    localparam int FLAG_FIRST = 1;
    localparam int FLAG_LAST  = 0;
    localparam int OFFSET_W   = CHAIN_ZERO_LSB;

    pwr_state_type    pwr_r;
    pwr_state_type    pwr_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [7:0]       chain_byte_r;
    logic [7:0]       chain_byte_nxt;
    logic             first_r;
    logic             first_nxt;
    logic             last_r;
    logic             last_nxt;
    logic [4:0]       geo_r;
    logic [4:0]       geo_nxt;
    logic             select_r;
    logic             select_nxt;
    access_type       access_r;
    access_type       access_nxt;
    logic [15:0]      offset_r;
    logic [15:0]      offset_nxt;

    logic [15:0]      switch_base;
    logic             am_a24;
    logic             am_a32;
    logic             am_mcst;
    logic             am_cblt;
    logic             base24_hit;
    logic             base32_hit;
    logic             chain_hit;
    logic             mcst_ok;
    logic             cblt_ok;
    logic             chain_cycle;
    logic             have_token;
    chain_pos_type    pos;
    logic             base_wr;
    logic [LAMP_COUNT-1:0] lamp_r;
    logic [LAMP_COUNT-1:0] lamp_nxt;
    logic [LAMP_COUNT-1:0] lamp_src;
    logic [OFFSET_W-1:0]   addr_offset;

    // power-up: clear buffer, then hold the configuring lamps
    always_comb begin
        pwr_nxt = pwr_r;
        cnt_nxt = cnt_r;
        case (pwr_r)
            PWR_CLEAR: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(CLEAR_COUNT - 1)) begin
                    pwr_nxt = PWR_CONFIG;
                    cnt_nxt = '0;
                end
            end
            PWR_CONFIG: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(CONFIG_COUNT - 1)) begin
                    pwr_nxt = PWR_READY;
                    cnt_nxt = '0;
                end
            end
            PWR_READY: begin
                cnt_nxt = '0;
            end
            default: begin
                pwr_nxt = PWR_CLEAR;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pwr_r <= PWR_CLEAR;
            cnt_r <= '0;
        end else begin
            pwr_r <= pwr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_buf_clear       = (pwr_r == PWR_CLEAR);
    assign o_acq_ready       = (pwr_r == PWR_READY);

    // lamps registered so a status glitch never reaches the front panel
    assign lamp_src = {i_buf_full, i_tdc_error, i_data_ready};
    always_comb begin
        lamp_nxt = lamp_src;
        if (pwr_r != PWR_READY) begin
            lamp_nxt = '1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            lamp_r <= '1;
        end else begin
            lamp_r <= lamp_nxt;
        end
    end

    assign o_full_lamp       = lamp_r[2];
    assign o_error_lamp      = lamp_r[1];
    assign o_data_ready_lamp = lamp_r[0];

    // fixed defaults; the engine always sees these, no register here can reprogram them
    assign o_trig_match    = TRIG_MATCH_RST;
    assign o_win_width     = WIN_WIDTH_RST;
    assign o_win_offset    = WIN_OFFSET_RST;
    assign o_extra_search  = EXTRA_SEARCH_RST;
    assign o_reject_margin = REJECT_MARGIN_RST;
    assign o_edge_leading  = EDGE_LEADING;
    assign o_fifo_size     = FIFO_SIZE_RST;
    assign o_max_hits      = HITS_UNLIMITED;
    assign o_all_chan_en   = 1'b1;
    assign o_chan_offset   = CHAN_OFFSET_RST;

    // address modifier classes
    assign switch_base = {i_switch_d3, i_switch_d2, i_switch_d1, i_switch_d0};
    assign am_a24  = (i_am >= AM_A24_LO) && (i_am <= AM_A24_HI);
    assign am_a32  = (i_am >= AM_A32_LO) && (i_am <= AM_A32_HI);
    assign am_mcst = (i_am == AM_MCST_SUP_BLT) || (i_am == AM_MCST_SUP_MBLT) ||
                     (i_am == AM_MCST_NP_BLT)  || (i_am == AM_MCST_NP_MBLT);
    assign am_cblt = (i_am == AM_CBLT_SUP_BLT) || (i_am == AM_CBLT_SUP_MBLT) ||
                     (i_am == AM_CBLT_NP_BLT)  || (i_am == AM_CBLT_NP_MBLT);

    // a24 uses the low two digits only
    assign base24_hit = am_a24 && (i_addr[23:A24_BASE_LSB] == switch_base[7:0]);
    assign base32_hit = am_a32 && (i_addr[31:A32_BASE_LSB] == switch_base);
    assign chain_hit  = (pos != CHAIN_INACTIVE)
                     && (i_addr[31:CHAIN_BYTE_LSB] == chain_byte_r)
                     && (i_addr[23:CHAIN_ZERO_LSB] == CHAIN_MID_FIELD);
    assign mcst_ok = chain_hit && i_write && am_mcst
                  && (addr_offset >= MCST_WR_LO) && (addr_offset <= MCST_WR_HI);
    assign cblt_ok = chain_hit && !i_write && am_cblt
                  && (addr_offset <= BUF_OFFSET_HI);
    assign chain_cycle = mcst_ok || cblt_ok;
    assign pos = chain_pos_type'({first_r, last_r});
    assign addr_offset = i_addr[OFFSET_W-1:0];

    chain_token u_token (
        .i_clock        (i_clock),
        .i_sys_rst      (i_sys_rst),
        .i_pos          (pos),
        .i_cycle_active (i_strobe),
        .i_chain_cycle  (chain_cycle),
        .i_iack_in_n    (i_iack_in_n),
        .i_board_done   (i_board_done),
        .o_have_token   (have_token),
        .o_iack_out_n   (o_iack_out_n)
    );

    // base hit wins over chain hit when both match
    always_comb begin
        select_nxt = 1'b0;
        access_nxt = ACC_NONE;
        // latched every cycle; only meaningful while select is high
        offset_nxt = addr_offset;
        if (i_strobe && o_acq_ready) begin
            if (base24_hit || base32_hit) begin
                select_nxt = 1'b1;
                access_nxt = ACC_BASE;
            end else if (mcst_ok && have_token) begin
                select_nxt = 1'b1;
                access_nxt = ACC_MCST;
            end else if (cblt_ok && have_token) begin
                select_nxt = 1'b1;
                access_nxt = ACC_CBLT;
            end
        end
    end

    // chain settings are written through the base address only
    assign base_wr = i_strobe && i_write && o_acq_ready && (base24_hit || base32_hit);
    always_comb begin
        chain_byte_nxt = chain_byte_r;
        first_nxt      = first_r;
        last_nxt       = last_r;
        geo_nxt        = geo_r;
        if (base_wr && (addr_offset == CHAIN_ADDR_OFFSET)) begin
            chain_byte_nxt = i_wdata[7:0];
        end
        if (base_wr && (addr_offset == CHAIN_CTRL_OFFSET)) begin
            first_nxt = i_wdata[FLAG_FIRST];
            last_nxt  = i_wdata[FLAG_LAST];
        end
        if (base_wr && (addr_offset == GEO_OFFSET)) begin
            geo_nxt = i_wdata[GEO_WIDTH-1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            select_r     <= 1'b0;
            access_r     <= ACC_NONE;
            offset_r     <= '0;
            chain_byte_r <= CHAIN_BYTE_RST;
            first_r      <= 1'b0;
            last_r       <= 1'b0;
            geo_r        <= GEO_RST;
        end else begin
            select_r     <= select_nxt;
            access_r     <= access_nxt;
            offset_r     <= offset_nxt;
            chain_byte_r <= chain_byte_nxt;
            first_r      <= first_nxt;
            last_r       <= last_nxt;
            geo_r        <= geo_nxt;
        end
    end

    assign o_select     = select_r;
    assign o_access     = access_r;
    assign o_offset     = offset_r;
    assign o_chain_byte = chain_byte_r;
    assign o_chain_pos  = {first_r, last_r};
    assign o_geo        = geo_r;
endmodule // slave_addr_decode

// File: rtl/addr_decode_pkg.sv
/*
  package for the slave address decoder: modifier codes, address fields,
  power-up defaults and timing counts.
  assumes a 20 MHz module clock.
*/
package addr_decode_pkg;
    localparam int unsigned CLOCK_HZ          = 20_000_000;
    localparam logic [5:0]  AM_A24_LO         = 6'h38;
    localparam logic [5:0]  AM_A24_HI         = 6'h3f;
    localparam logic [5:0]  AM_A32_LO         = 6'h08;
    localparam logic [5:0]  AM_A32_HI         = 6'h0f;
    localparam logic [5:0]  AM_MCST_SUP_BLT   = 6'h0e;
    localparam logic [5:0]  AM_MCST_SUP_MBLT  = 6'h0d;
    localparam logic [5:0]  AM_MCST_NP_BLT    = 6'h0a;
    localparam logic [5:0]  AM_MCST_NP_MBLT   = 6'h09;
    localparam logic [5:0]  AM_CBLT_SUP_BLT   = 6'h0f;
    localparam logic [5:0]  AM_CBLT_SUP_MBLT  = 6'h0c;
    localparam logic [5:0]  AM_CBLT_NP_BLT    = 6'h0b;
    localparam logic [5:0]  AM_CBLT_NP_MBLT   = 6'h08;
    localparam int          A24_BASE_LSB      = 16;
    localparam int          A32_BASE_LSB      = 16;
    localparam int          CHAIN_BYTE_LSB    = 24;
    localparam int          CHAIN_ZERO_LSB    = 16;
    localparam logic [7:0]  CHAIN_BYTE_RST    = 8'haa;
    localparam logic [7:0]  CHAIN_MID_FIELD   = 8'h00;
    localparam int          GEO_WIDTH         = 5;
    localparam logic [4:0]  GEO_RST           = 5'h00;
    localparam logic [15:0] BUF_OFFSET_LO     = 16'h0000;
    localparam logic [15:0] BUF_OFFSET_HI     = 16'h0ffc;
    localparam logic [15:0] CHAIN_ADDR_OFFSET = 16'h1010;
    localparam logic [15:0] CHAIN_CTRL_OFFSET = 16'h1012;
    localparam logic [15:0] GEO_OFFSET        = 16'h1000;
    localparam logic [15:0] MCST_WR_LO        = 16'h1000;
    localparam logic [15:0] MCST_WR_HI        = 16'h10ff;
    localparam logic        TRIG_MATCH_RST    = 1'b0;
    localparam logic [15:0] WIN_WIDTH_RST     = 16'h0014;
    localparam logic [15:0] WIN_OFFSET_RST    = 16'hffd8;
    localparam logic [15:0] EXTRA_SEARCH_RST  = 16'h0008;
    localparam logic [15:0] REJECT_MARGIN_RST = 16'h0004;
    localparam logic        EDGE_LEADING      = 1'b1;
    localparam int          RES_PS            = 25;
    localparam int          DEAD_NS           = 5;
    localparam logic [9:0]  FIFO_SIZE_RST     = 10'h100;
    localparam logic [7:0]  HITS_UNLIMITED    = 8'h00;
    localparam logic [11:0] CHAN_OFFSET_RST   = 12'h000;
    localparam int          CONFIG_MS         = 2000;
    localparam int          CONFIG_CYCLES     = CLOCK_HZ / 1000 * CONFIG_MS;
    localparam int          BUF_CLEAR_WORDS   = 32768;

    typedef enum logic [1:0] {
        CHAIN_INACTIVE,
        CHAIN_LAST,
        CHAIN_FIRST,
        CHAIN_MIDDLE
    } chain_pos_type;

    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_BASE,
        ACC_MCST,
        ACC_CBLT
    } access_type;

    typedef enum {
        PWR_CLEAR,
        PWR_CONFIG,
        PWR_READY
    } pwr_state_type;
endpackage

// File: rtl/chain_token.sv
/*
  token holder for the chained access daisy chain.
  assumes the backplane acknowledge chain arrives synchronous to i_clock.
*/
`timescale 1ns/1ps
module chain_token
    import addr_decode_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_sys_rst,
    input  wire chain_pos_type i_pos,
    input  wire logic          i_cycle_active,
    input  wire logic          i_chain_cycle,
    input  wire logic          i_iack_in_n,
    input  wire logic          i_board_done,
    output logic               o_have_token,
    output logic               o_iack_out_n
);
    logic done_r;
    logic done_nxt;

    // first board owns the token from the start; others wait for iack
    logic has_in;
    always_comb begin
        has_in   = (i_pos == CHAIN_FIRST) ? 1'b1 : ~i_iack_in_n;
        done_nxt = done_r;
        if (!i_cycle_active) begin
            done_nxt = 1'b0;
        end else if (i_chain_cycle && has_in && i_board_done) begin
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

    always_comb begin
        o_have_token = 1'b0;
        o_iack_out_n = 1'b1;
        if (i_pos == CHAIN_INACTIVE) begin
            o_iack_out_n = i_iack_in_n;
        end else if (i_chain_cycle && has_in) begin
            o_have_token = ~done_r;
            o_iack_out_n = ~done_r;
        end
    end
endmodule // chain_token

// File: dv/slave_addr_decode_chk.sv
/*
  checker for the slave address decoder, sees only its ports.
  assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
module slave_addr_decode_chk #(
    parameter int CONFIG_COUNT = 8,
    parameter int CLEAR_COUNT  = 4
) (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic [3:0]  i_switch_d3,
    input wire logic [3:0]  i_switch_d2,
    input wire logic [3:0]  i_switch_d1,
    input wire logic [3:0]  i_switch_d0,
    input wire logic [31:0] i_addr,
    input wire logic [5:0]  i_am,
    input wire logic        i_write,
    input wire logic        i_strobe,
    input wire logic        i_iack_in_n,
    input wire logic        o_select,
    input wire logic [1:0]  o_access,
    input wire logic        o_iack_out_n,
    input wire logic [7:0]  o_chain_byte,
    input wire logic [1:0]  o_chain_pos,
    input wire logic        o_buf_clear,
    input wire logic        o_acq_ready,
    input wire logic [15:0] o_win_width,
    input wire logic [15:0] o_win_offset
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    chk_select_cause: assert property (
        o_select |-> $past(i_strobe) && $past(o_acq_ready)) else $error("select without cause");
    chk_a24_base_hit: assert property (
        i_strobe && o_acq_ready && i_am >= 6'h38 && i_addr[23:16] == {i_switch_d1, i_switch_d0}
        |=> o_select && o_access == 2'd1) else $error("A24 base access missed");
    chk_a32_base_hit: assert property (
        i_strobe && o_acq_ready && i_am inside {[6'h08:6'h0f]}
        && i_addr[31:16] == {i_switch_d3, i_switch_d2, i_switch_d1, i_switch_d0}
        |=> o_select && o_access == 2'd1) else $error("A32 base access missed");
    chk_chain_byte_match: assert property (
        o_select && o_access[1] |-> $past(i_addr[31:24]) == $past(o_chain_byte)
        && $past(o_chain_pos) != 2'b00) else $error("chain hit on wrong byte or inactive");
    chk_chained_read_only: assert property (
        o_select && o_access == 2'd3 |-> !$past(i_write) && $past(i_addr[23:16]) == 8'h00
        && $past(i_addr[15:0]) <= 16'h0ffc && $past(i_am) inside {6'h0f, 6'h0c, 6'h0b, 6'h08})
        else $error("bad chained read accepted");
    chk_mcst_write_only: assert property (
        o_select && o_access == 2'd2 |-> $past(i_write) && $past(i_addr[23:16]) == 8'h00
        && $past(i_am) inside {6'h0e, 6'h0d, 6'h0a, 6'h09}) else $error("bad multicast accepted");
    chk_inactive_token_pass: assert property (
        o_chain_pos == 2'b00 |-> o_iack_out_n == i_iack_in_n) else $error("token held");
    chk_clear_then_ready: assert property (
        o_acq_ready |-> !o_buf_clear) else $error("ready while clearing");
    chk_config_phase: assert property (
        $fell(o_buf_clear) |-> !o_acq_ready [*4]) else $error("no configuring phase");
    chk_window_default: assert property (
        o_win_width == 16'h0014 && o_win_offset == 16'hffd8) else $error("window default lost");
endmodule // slave_addr_decode_chk

bind slave_addr_decode slave_addr_decode_chk #(
    .CONFIG_COUNT(CONFIG_COUNT), .CLEAR_COUNT(CLEAR_COUNT)
) chk_inst (
    .i_clock, .i_sys_rst, .i_switch_d3, .i_switch_d2, .i_switch_d1, .i_switch_d0,
    .i_addr, .i_am, .i_write, .i_strobe, .i_iack_in_n, .o_select, .o_access,
    .o_iack_out_n, .o_chain_byte, .o_chain_pos, .o_buf_clear, .o_acq_ready,
    .o_win_width, .o_win_offset
);

// File: dv/vme_master_model.sv
/*
  crate master model: drives one bus cycle at a time.
  assumes start and stop are called at falling clock edges.
*/
`timescale 1ns/1ps
module vme_master_model (
    input  wire logic   i_clock,
    output logic [31:0] o_addr,
    output logic [5:0]  o_am,
    output logic        o_write,
    output logic        o_strobe,
    output logic [31:0] o_wdata
);
    initial begin
        {o_addr, o_am, o_write, o_strobe, o_wdata} = '0;
    end
    task automatic start(input logic [31:0] a, input logic [5:0] m, input logic w,
                         input logic [31:0] d);
        @(negedge i_clock);
        o_addr   = a;
        o_am     = m;
        o_write  = w;
        o_wdata  = d;
        o_strobe = 1'b1;
    endtask
    // released lines invert, so stale values never look like a held cycle
    task automatic stop();
        o_strobe = 1'b0;
        o_addr   = ~o_addr;
        o_am     = ~o_am;
        o_write  = ~o_write;
        o_wdata  = ~o_wdata;
    endtask
endmodule // vme_master_model

// File: dv/vme_slave_address_decode_test.sv
/*
  bench for the slave address decoder: power-up, base, multicast, chained, token.
  assumes the master model drives the bus side and the bench the rest.
*/
`timescale 1ns/1ps
module vme_slave_address_decode_test;
    localparam int         CFG = 8;
    localparam int         CLR = 4;
    localparam logic [5:0] mc [4] = '{6'h0e, 6'h0d, 6'h0a, 6'h09};
    localparam logic [5:0] cb [4] = '{6'h0f, 6'h0c, 6'h0b, 6'h08};
    logic        i_clock = 1'b0, i_sys_rst = 1'b1, i_iack_in_n = 1'b1, i_board_done = 1'b0;
    logic        i_buf_full = 1'b0, i_tdc_error = 1'b0, i_data_ready = 1'b0;
    logic [3:0]  i_switch_d3 = 4'hc, i_switch_d2 = 4'hc, i_switch_d1 = 4'h1, i_switch_d0 = 4'h1;
    logic [31:0] i_addr, i_wdata;
    logic [5:0]  i_am;
    logic        i_write, i_strobe, o_select, o_iack_out_n, o_buf_clear, o_acq_ready;
    logic        o_trig_match, o_edge_leading, o_all_chan_en;
    logic        o_full_lamp, o_error_lamp, o_data_ready_lamp;
    logic [1:0]  o_access, o_chain_pos;
    logic [7:0]  o_chain_byte, o_max_hits;
    logic [4:0]  o_geo;
    logic [15:0] o_win_width, o_win_offset, o_extra_search, o_reject_margin, o_offset;
    logic [9:0]  o_fifo_size;
    logic [11:0] o_chan_offset;
    int          mismatches = 0, checks_done = 0, cycles = 0;

    vme_master_model master (.i_clock, .o_addr(i_addr), .o_am(i_am), .o_write(i_write),
                             .o_strobe(i_strobe), .o_wdata(i_wdata));
    slave_addr_decode #(.CONFIG_COUNT(CFG), .CLEAR_COUNT(CLR)) dut (
        .i_clock, .i_sys_rst, .i_switch_d3, .i_switch_d2, .i_switch_d1, .i_switch_d0,
        .i_addr, .i_am, .i_write, .i_strobe, .i_wdata, .i_iack_in_n, .i_board_done,
        .i_buf_full, .i_tdc_error, .i_data_ready, .o_select, .o_access, .o_offset,
        .o_iack_out_n, .o_chain_byte, .o_chain_pos, .o_geo, .o_buf_clear, .o_acq_ready,
        .o_trig_match, .o_win_width, .o_win_offset, .o_extra_search, .o_reject_margin,
        .o_edge_leading, .o_fifo_size, .o_max_hits, .o_all_chan_en, .o_chan_offset,
        .o_full_lamp, .o_error_lamp, .o_data_ready_lamp);

    initial begin
        forever #25 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // acc 0 means the cycle must be refused
    task automatic access(input logic [31:0] a, input logic [5:0] m, input logic w,
                          input logic [31:0] d, input logic [1:0] acc);
        master.start(a, m, w, d);
        @(negedge i_clock);
        chk(o_select === (acc != 2'd0)
            && (acc == 2'd0 || (o_access === acc && o_offset === a[15:0])),
            $sformatf("decode %h am %h", a, m));
        master.stop();
    endtask

    task automatic power_up();
        int n;
        chk(o_buf_clear === 1'b1 && (o_full_lamp & o_error_lamp & o_data_ready_lamp) === 1'b1,
            "reset state");
        chk(o_chain_byte === 8'haa && o_chain_pos === 2'b00, "chain reset");
        i_sys_rst = 1'b0;
        n = 0;
        while (o_acq_ready !== 1'b1 && n < 100) begin
            @(negedge i_clock);
            n++;
        end
        chk(n >= CLR + CFG - 1 && n <= CLR + CFG + 2 && o_buf_clear === 1'b0, "ready");
        chk({o_trig_match, o_win_width, o_win_offset, o_extra_search, o_reject_margin}
            === {1'b0, 16'h0014, 16'hffd8, 16'h0008, 16'h0004}, "window");
        chk({o_edge_leading, o_fifo_size, o_max_hits, o_all_chan_en, o_chan_offset}
            === {1'b1, 10'h100, 8'h00, 1'b1, 12'h000}, "converter");
        {i_buf_full, i_tdc_error, i_data_ready} = 3'b010;
        @(negedge i_clock);
        chk({o_full_lamp, o_error_lamp, o_data_ready_lamp} === 3'b010, "lamps");
        {i_buf_full, i_tdc_error, i_data_ready} = 3'b101;
        @(negedge i_clock);
        chk({o_full_lamp, o_error_lamp, o_data_ready_lamp} === 3'b101, "lamps");
    endtask
    task automatic base_modes();
        for (int m = 8; m < 16; m++) begin
            access(32'hcc11_0000, 6'(m), 1'b0, 32'h0, 2'd1);
            access(32'h0011_0000, 6'(m + 48), 1'b0, 32'h0, 2'd1);
        end
        access(32'hcc12_0000, 6'h0d, 1'b0, 32'h0, 2'd0);
        access(32'h0012_0000, 6'h3d, 1'b0, 32'h0, 2'd0);
        access(32'hcc11_0000, 6'h29, 1'b0, 32'h0, 2'd0);
    endtask
    task automatic chain_setup();
        access(32'haa00_0000, 6'h0f, 1'b0, 32'h0, 2'd0);
        access(32'haa00_1020, 6'h0e, 1'b1, 32'h0, 2'd0);
        i_iack_in_n = 1'b0;
        @(negedge i_clock);
        chk(o_iack_out_n === 1'b0, "inactive pass");
        i_iack_in_n = 1'b1;
        access(32'hcc11_1010, 6'h0d, 1'b1, 32'h55, 2'd1);
        access(32'hcc11_1000, 6'h0d, 1'b1, 32'h05, 2'd1);
        for (int f = 0; f < 4; f++) begin
            access(32'hcc11_1012, 6'h0d, 1'b1, 32'(3 - f), 2'd1);
            chk(o_chain_pos === 2'(3 - f), "flags");
        end
        chk(o_chain_byte === 8'h55 && o_geo === 5'h05, "chain regs");
    endtask
    task automatic chain_traffic();
        access(32'hcc11_1012, 6'h0d, 1'b1, 32'h2, 2'd1);
        foreach (mc[i]) begin
            access(32'h5500_1020, mc[i], 1'b1, 32'h0, 2'd2);
            access(32'h5500_0000, cb[i], 1'b0, 32'h0, 2'd3);
        end
        access(32'h5500_1020, 6'h0e, 1'b0, 32'h0, 2'd0);
        access(32'h5500_2000, 6'h0e, 1'b1, 32'h0, 2'd0);
        access(32'h5500_0000, 6'h0f, 1'b1, 32'h0, 2'd0);
        access(32'h5500_1000, 6'h0f, 1'b0, 32'h0, 2'd0);
        access(32'h5501_0000, 6'h0f, 1'b0, 32'h0, 2'd0);
        access(32'h5600_0000, 6'h0f, 1'b0, 32'h0, 2'd0);
        access(32'h5500_1020, 6'h3d, 1'b1, 32'h0, 2'd0);
    endtask
    task automatic token_pass();
        access(32'hcc11_1012, 6'h0d, 1'b1, 32'h1, 2'd1);
        access(32'h5500_0000, 6'h0b, 1'b0, 32'h0, 2'd0);
        i_iack_in_n = 1'b0;
        access(32'h5500_0000, 6'h0b, 1'b0, 32'h0, 2'd3);
        i_iack_in_n = 1'b1;
        access(32'hcc11_1012, 6'h0d, 1'b1, 32'h2, 2'd1);
        master.start(32'h5500_0000, 6'h0c, 1'b0, 32'h0);
        @(negedge i_clock);
        chk(o_select === 1'b1 && o_iack_out_n === 1'b1, "holder");
        i_board_done = 1'b1;
        @(negedge i_clock);
        chk(o_iack_out_n === 1'b0, "passed on");
        @(negedge i_clock);
        chk(o_select === 1'b0 && o_iack_out_n === 1'b0, "released");
        master.stop();
        i_board_done = 1'b0;
    endtask
    // reset in mid-run: defaults return, software must program the chain again
    task automatic reset_again();
        int n;
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clock);
        chk(o_chain_byte === 8'haa && o_chain_pos === 2'b00 && o_geo === 5'h00
            && o_buf_clear === 1'b1 && o_select === 1'b0 && o_error_lamp === 1'b1,
            "defaults back");
        i_sys_rst = 1'b0;
        access(32'hcc11_0000, 6'h0d, 1'b0, 32'h0, 2'd0);
        n = 0;
        while (o_acq_ready !== 1'b1 && n < 100) begin
            @(negedge i_clock);
            n++;
        end
        access(32'h5500_1020, 6'h0e, 1'b1, 32'h0, 2'd0);
        access(32'hcc11_1010, 6'h0d, 1'b1, 32'h55, 2'd1);
        access(32'hcc11_1012, 6'h0d, 1'b1, 32'h2, 2'd1);
        access(32'h5500_1020, 6'h0e, 1'b1, 32'h0, 2'd2);
    endtask

    initial begin
        repeat (16) @(negedge i_clock);
        power_up();
        base_modes();
        chain_setup();
        chain_traffic();
        token_pass();
        reset_again();
        report_and_stop();
    end
endmodule // vme_slave_address_decode_test
